/* File: design/sps_dwell_timer.sv */
// Purpose: dwell timer counting whole milliseconds from a cycle divider
// Assumes: load is a one-cycle pulse; ms value is held by the caller
// Notes:   a zero dwell raises expire two cycles after load
`timescale 1ns/1ns
module sps_dwell_timer
	import sps_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        load,
	input  wire logic [15:0] load_ms,
	output logic             expire
);

	typedef struct packed {
		logic        busy;
		logic [15:0] ms_left;
		logic [31:0] div;
		logic        expire;
	} sps_tmr_type;

	sps_tmr_type s_q;
	sps_tmr_type s_d;

	// millisecond divider and down counter
	always_comb
	begin
		s_d        = s_q;
		s_d.expire = 1'b0;
		if (load)
		begin
			s_d.busy    = 1'b1;
			s_d.ms_left = load_ms;
			s_d.div     = 32'h0;
		end
		else if (s_q.busy)
		begin
			if (s_q.ms_left == 16'h0)
			begin
				s_d.busy   = 1'b0;
				s_d.expire = 1'b1;
			end
			else if (s_q.div == 32'(TICK_CYCLES - 1))
			begin
				s_d.div     = 32'h0;
				s_d.ms_left = s_q.ms_left - 16'h1;
			end
			else
			begin
				s_d.div = s_q.div + 32'h1;
			end
		end
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign expire = s_q.expire;

endmodule

/* File: design/sps_pkg.sv */
// Purpose: shared constants and types of the stored positioning sequencer
// Assumes: one 20 MHz clock, register access over AXI4-Lite with 32-bit data
// Notes:   entry word layout, register offsets and timing counts live here
package sps_pkg;

	// timing: clock period and the one millisecond dwell tick
	localparam int CLK_PERIOD_NS   = 50;
	localparam int DWELL_TICK_NS   = 1_000_000;
	localparam int TICK_CYCLES_DEF = DWELL_TICK_NS / CLK_PERIOD_NS;

	// entry table and chain limits
	localparam int         ENTRY_COUNT = 64;
	localparam logic [5:0] LAST_ENTRY  = 6'h3F;
	localparam int         MAX_CHAIN   = 4;
	localparam int         SCAN_DEPTH  = 5;

	// register byte offsets
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_STATUS   = 12'h004;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFF_IRQ_EN   = 12'h00C;
	localparam logic [11:0] OFF_IRQ_CLR  = 12'h010;
	localparam logic [11:0] OFF_TABLE    = 12'h100;

	// entry word fields
	localparam int FN_LSB    = 0;
	localparam int DIR_BIT   = 2;
	localparam int DWELL_LSB = 16;

	// control, status and interrupt fields
	localparam int CTRL_ALARM_CLR = 0;
	localparam int ST_READY       = 0;
	localparam int ST_MOVE        = 1;
	localparam int ST_ALARM       = 2;
	localparam int ST_STATE_LSB   = 4;
	localparam int ST_ENTRY_LSB   = 8;
	localparam int ST_LEN_LSB     = 16;
	localparam int IRQ_DONE       = 0;
	localparam int IRQ_ALARM      = 1;
	localparam int IRQ_DWELL      = 2;
	localparam int IRQ_BITS       = 3;

	// reset values and bus answers
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// operation function of an entry
	typedef enum logic [1:0] {
		FN_SINGLE  = 2'h0,
		FN_LINKED  = 2'h1,
		FN_LINKED2 = 2'h2,
		FN_PUSH    = 2'h3
	} sps_func_type;

	// sequencer states, gray coded along idle, run, dwell, alarm
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_RUN    = 3'h1,
		ST_DWELL  = 3'h3,
		ST_ALARMS = 3'h2
	} sps_state_type;

endpackage

/* File: design/sps_sequencer.sv */
// What this block does
// - single-motion entry runs one move with its own data, then stops.
// - ready drops once the operation begins; host releases start afterwards.
// - ready returns only after the whole operation, linked entries included.
// - select and start arriving in the same cycle are accepted.
// - linked-motion entry continues into the next entry without stopping.
// - chain ends at first single-motion or push entry; motor stops after it.
// - at most four entries per chain, both linked kinds counted.
// - chain of five or more raises the data error alarm at start.
// - direction reversal inside a linked-motion chain raises the alarm.
// - entry 63 never links on to entry 0; it runs alone.
// - linked chain keeps acceleration of the entry that started it, or of the entry after the latest dwell.
// - chain ending in push uses push speed as starting speed.
// - linked-motion 2 may reverse; dwell after the entry, then run next.
// - move drops at segment end during dwell; ready stays low.
// - dwell expiry starts the next entry and raises move together.
//
// Purpose: sequences stored positioning entries for a motion generator
// Assumes: seg_done pulses once per started segment; inputs synchronous to aclk
// Notes:   table and control registers reached over AXI4-Lite
`timescale 1ns/1ns
module sps_sequencer
	import sps_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [5:0]  entry_select_inputs,
	input  wire logic        start,
	input  wire logic        seg_done,
	output logic             ready,
	output logic             move,
	output logic             alarm,
	output logic             seg_start,
	output logic [5:0]       seg_entry,
	output logic             seg_blend,
	output logic [5:0]       accel_entry,
	output logic             push_start_speed,
	output logic             irq
);

	typedef struct packed {
		logic [ENTRY_COUNT-1:0][31:0] table_w;
		logic                         aw_have;
		logic [11:0]                  awaddr;
		logic                         w_have;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic [IRQ_BITS-1:0]          irq_stat;
		logic [IRQ_BITS-1:0]          irq_en;
		logic                         irq;
		sps_state_type                state;
		logic                         start_prev;
		logic [5:0]                   cur;
		logic [2:0]                   chain_len;
		logic                         ready;
		logic                         move;
		logic                         alarm;
		logic                         seg_start;
		logic                         seg_blend;
		logic [5:0]                   accel_entry;
		logic                         push_speed;
		logic                         dwell_load;
		logic [15:0]                  dwell_ms;
	} sps_state_all_type;

	sps_state_all_type s_q;
	sps_state_all_type s_d;
	logic              dwell_expire;

	// merge a write word into a register under byte strobes
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return r;
	endfunction

	// function field of a stored entry
	function automatic sps_func_type entry_fn(input logic [31:0] w);
		return sps_func_type'(w[FN_LSB +: 2]);
	endfunction

	// true when the entry links on to the next one (63 never does)
	function automatic logic links_on(input logic [31:0] w, input logic [5:0] n);
		return (n != LAST_ENTRY) &&
			((entry_fn(w) == FN_LINKED) || (entry_fn(w) == FN_LINKED2));
	endfunction

	// walk the chain from entry n: length (saturating at five) and last function
	function automatic logic [4:0] chain_scan(input logic [ENTRY_COUNT-1:0][31:0] t,
		input logic [5:0] n);
		logic [2:0]   len;
		logic         stop;
		logic [5:0]   idx;
		sps_func_type last;
		len  = 3'h0;
		stop = 1'b0;
		idx  = n;
		last = FN_SINGLE;
		for (int i = 0; i < SCAN_DEPTH; i++)
		begin
			if (!stop)
			begin
				len  = len + 3'h1;
				last = entry_fn(t[idx]);
				if (links_on(t[idx], idx))
					idx = idx + 6'h1;
				else
					stop = 1'b1;
			end
		end
		return {len, 2'(last)};
	endfunction

	// register read decode
	function automatic logic [32:0] reg_read(input sps_state_all_type s, input logic [11:0] a);
		logic [31:0] v;
		logic        ok;
		v  = 32'h0;
		ok = 1'b1;
		if (a >= OFF_TABLE && a < OFF_TABLE + 12'(ENTRY_COUNT * 4))
			v = s.table_w[a[7:2]];
		else if (a == OFF_STATUS)
		begin
			v[ST_READY]             = s.ready;
			v[ST_MOVE]              = s.move;
			v[ST_ALARM]             = s.alarm;
			v[ST_STATE_LSB +: 3]    = s.state;
			v[ST_ENTRY_LSB +: 6]    = s.cur;
			v[ST_LEN_LSB +: 3]      = s.chain_len;
		end
		else if (a == OFF_IRQ_STAT)
			v[IRQ_BITS-1:0] = s.irq_stat;
		else if (a == OFF_IRQ_EN)
			v[IRQ_BITS-1:0] = s.irq_en;
		else if (a != OFF_CTRL && a != OFF_IRQ_CLR)
			ok = 1'b0;
		return {ok, v};
	endfunction

	// next state of bus slave and sequencer
	always_comb
	begin
		logic [4:0]          scan;
		logic                go;
		logic                wr_fire;
		logic [IRQ_BITS-1:0] ev;
		logic [IRQ_BITS-1:0] clr;
		logic [32:0]         rd;
		logic [31:0]         nxt_w;
		logic [31:0]         cur_w;
		scan    = chain_scan(s_q.table_w, entry_select_inputs);
		go      = 1'b0;
		wr_fire = 1'b0;
		ev      = '0;
		clr     = '0;
		rd      = '0;
		cur_w   = s_q.table_w[s_q.cur];
		nxt_w   = s_q.table_w[s_q.cur + 6'h1];
		s_d     = s_q;

		// write address and data are taken in either order
		if (s_q.awready && s_axi_awvalid)
		begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
		end
		if (s_q.wready && s_axi_wvalid)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
		begin
			wr_fire     = 1'b1;
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			rd          = reg_read(s_q, s_q.awaddr);
			s_d.bresp   = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready  = !s_d.w_have && !s_d.bvalid;

		// register write effects
		if (wr_fire)
		begin
			if (s_q.awaddr >= OFF_TABLE && s_q.awaddr < OFF_TABLE + 12'(ENTRY_COUNT * 4))
				s_d.table_w[s_q.awaddr[7:2]] = strb_merge(s_q.table_w[s_q.awaddr[7:2]],
					s_q.wdata, s_q.wstrb);
			else if (s_q.awaddr == OFF_IRQ_EN)
				s_d.irq_en = IRQ_BITS'(strb_merge(32'(s_q.irq_en), s_q.wdata,
					s_q.wstrb));
			else if (s_q.awaddr == OFF_IRQ_CLR && s_q.wstrb[0])
				clr = s_q.wdata[IRQ_BITS-1:0];
			else if (s_q.awaddr == OFF_CTRL && s_q.wstrb[0] &&
				s_q.wdata[CTRL_ALARM_CLR] && s_q.state == ST_ALARMS)
			begin
				s_d.alarm = 1'b0;
				s_d.state = ST_IDLE;
				s_d.ready = 1'b1;
			end
		end

		// read channel answers one cycle after the address is taken
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_q.arready && s_axi_arvalid)
		begin
			rd          = reg_read(s_q, s_axi_araddr);
			s_d.rvalid  = 1'b1;
			s_d.rdata   = rd[31:0];
			s_d.rresp   = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.arready = !s_d.rvalid;

		// start is taken on its rising edge while ready, select sampled alongside
		s_d.start_prev = start;
		s_d.seg_start  = 1'b0;
		s_d.dwell_load = 1'b0;
		go = start && !s_q.start_prev && s_q.ready && s_q.state == ST_IDLE;

		case (s_q.state)
			ST_IDLE:
			begin
				if (go)
				begin
					s_d.ready     = 1'b0;
					s_d.cur       = entry_select_inputs;
					s_d.chain_len = scan[4:2];
					if (scan[4:2] > 3'(MAX_CHAIN))
					begin
						s_d.alarm = 1'b1;
						s_d.state = ST_ALARMS;
						ev[IRQ_ALARM] = 1'b1;
					end
					else
					begin
						s_d.state       = ST_RUN;
						s_d.move        = 1'b1;
						s_d.seg_start   = 1'b1;
						s_d.seg_blend   = links_on(s_q.table_w[entry_select_inputs],
							entry_select_inputs) &&
							entry_fn(s_q.table_w[entry_select_inputs]) == FN_LINKED;
						s_d.accel_entry = entry_select_inputs;
						s_d.push_speed  = sps_func_type'(scan[1:0]) == FN_PUSH;
					end
				end
			end
			ST_RUN:
			begin
				if (seg_done)
				begin
					if (!links_on(cur_w, s_q.cur))
					begin
						s_d.state      = ST_IDLE;
						s_d.move       = 1'b0;
						s_d.ready      = 1'b1;
						s_d.seg_blend  = 1'b0;
						s_d.push_speed = 1'b0;
						ev[IRQ_DONE]   = 1'b1;
					end
					else if (entry_fn(cur_w) == FN_LINKED)
					begin
						if (nxt_w[DIR_BIT] != cur_w[DIR_BIT])
						begin
							s_d.state     = ST_ALARMS;
							s_d.move      = 1'b0;
							s_d.alarm     = 1'b1;
							s_d.seg_blend = 1'b0;
							ev[IRQ_ALARM] = 1'b1;
						end
						else
						begin
							// continue without rest, keep the first entry's ramps
							s_d.cur       = s_q.cur + 6'h1;
							s_d.seg_start = 1'b1;
							s_d.seg_blend = links_on(nxt_w, s_q.cur + 6'h1) &&
								entry_fn(nxt_w) == FN_LINKED;
						end
					end
					else
					begin
						// linked-motion 2: stop and dwell, direction may reverse
						s_d.state      = ST_DWELL;
						s_d.move       = 1'b0;
						s_d.seg_blend  = 1'b0;
						s_d.dwell_load = 1'b1;
						s_d.dwell_ms   = cur_w[DWELL_LSB +: 16];
						ev[IRQ_DWELL]  = 1'b1;
					end
				end
			end
			ST_DWELL:
			begin
				if (dwell_expire)
				begin
					s_d.state       = ST_RUN;
					s_d.cur         = s_q.cur + 6'h1;
					s_d.move        = 1'b1;
					s_d.seg_start   = 1'b1;
					s_d.accel_entry = s_q.cur + 6'h1;
					s_d.seg_blend   = links_on(nxt_w, s_q.cur + 6'h1) &&
						entry_fn(nxt_w) == FN_LINKED;
				end
			end
			ST_ALARMS:
			begin
				s_d.move = 1'b0;
			end
			default:
			begin
				s_d.state = ST_IDLE;
			end
		endcase

		// sticky interrupt status: a new event wins over a clear
		s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
		s_d.irq      = |(s_d.irq_stat & s_d.irq_en);
	end

	// state register with synchronous reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q         <= '0;
			s_q.state   <= ST_IDLE;
			s_q.ready   <= 1'b1;
			s_q.irq_en  <= IRQ_EN_RST;
		end
		else
			s_q <= s_d;
	end

	// millisecond dwell timer
	sps_dwell_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_dwell (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (s_q.dwell_load),
		.load_ms (s_q.dwell_ms),
		.expire  (dwell_expire)
	);

	// outputs straight from the state register
	assign s_axi_awready    = s_q.awready;
	assign s_axi_wready     = s_q.wready;
	assign s_axi_bresp      = s_q.bresp;
	assign s_axi_bvalid     = s_q.bvalid;
	assign s_axi_arready    = s_q.arready;
	assign s_axi_rdata      = s_q.rdata;
	assign s_axi_rresp      = s_q.rresp;
	assign s_axi_rvalid     = s_q.rvalid;
	assign ready            = s_q.ready;
	assign move             = s_q.move;
	assign alarm            = s_q.alarm;
	assign seg_start        = s_q.seg_start;
	assign seg_entry        = s_q.cur;
	assign seg_blend        = s_q.seg_blend;
	assign accel_entry      = s_q.accel_entry;
	assign push_start_speed = s_q.push_speed;
	assign irq              = s_q.irq;

endmodule

/* File: sim/sps_host_model.sv */
// Purpose: host controller on the select and start inputs, plus motion generator
// Assumes: every started segment reaches its target after MOVE_CYCLES
// Notes:   select lines turn stale (inverted) once start is released
`timescale 1ns/1ns
module sps_host_model
	import sps_pkg::*;
#(
	parameter int MOVE_CYCLES = 6
)
(
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  ready,
	input  wire logic  seg_start,
	output logic [5:0] entry_select_inputs,
	output logic       start,
	output logic       seg_done
);
	int left_q;

	initial
	begin
		entry_select_inputs = 6'h00;
		start = 1'b0;
		seg_done = 1'b0;
		left_q = 0;
	end

	// motion generator: one done pulse per started segment
	always @(posedge aclk)
	begin
		seg_done <= 1'b0;
		if (!aresetn)
			left_q <= 0;
		else if (seg_start)
			left_q <= MOVE_CYCLES;
		else if (left_q != 0)
		begin
			left_q <= left_q - 1;
			seg_done <= (left_q == 1);
		end
	end

	// one start handshake for entry n
	task automatic run(input logic [5:0] n);
		int k;
		k = 0;
		while (ready !== 1'b1 && k < 2000)
		begin
			@(posedge aclk);
			k++;
		end
		entry_select_inputs <= n;
		start <= 1'b1; // select and start in one update
		k = 0;
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (ready !== 1'b0 && k < 50);
		start <= 1'b0;
		entry_select_inputs <= ~n;
		@(posedge aclk);
	endtask
endmodule

/* File: sim/sps_seq_properties.sv */
// Purpose: concurrent checks on the sequencer handshake and segment ports
// Assumes: one clock domain; sees only top-level ports
// Notes:   bound to every sps_sequencer instance below
`timescale 1ns/1ns
module sps_seq_properties
	import sps_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [5:0] entry_select_inputs,
	input wire logic       start,
	input wire logic       seg_done,
	input wire logic       ready,
	input wire logic       move,
	input wire logic       alarm,
	input wire logic       seg_start,
	input wire logic [5:0] seg_entry,
	input wire logic       seg_blend,
	input wire logic [5:0] accel_entry
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// start handshake and selection
	AST_START_TAKEN: assert property (ready && $rose(start) |=> !ready && (seg_start || alarm))
		else $error("start edge not taken");
	AST_SELECT_USED: assert property (ready && $rose(start) |=> alarm || seg_entry == $past(entry_select_inputs))
		else $error("first segment not the selected entry");
	// ready only when at rest, and only after a finish
	AST_IDLE_STILL: assert property (ready |-> !move && !seg_start)
		else $error("motion while ready");
	AST_READY_CAUSE: assert property ($rose(ready) |-> $past(seg_done) || $past(alarm))
		else $error("ready returned without a finish");
	// linked chaining, move rise, alarm halt and segment start pulse width
	AST_BLEND_NEXT: assert property (seg_done && seg_blend |=> seg_start && seg_entry == $past(seg_entry) + 6'h01 || alarm)
		else $error("linked segment did not run into the next entry");
	AST_NO_WRAP: assert property (seg_done && move && seg_entry == LAST_ENTRY |=> ready && !move)
		else $error("last entry did not stop");
	AST_ACCEL_KEPT: assert property (seg_start && $past(seg_blend) |-> accel_entry == $past(accel_entry))
		else $error("accel entry changed inside a chain");
	AST_MOVE_RISE: assert property ($rose(move) |-> seg_start)
		else $error("move rose without a segment start");
	AST_ALARM_HALT: assert property (alarm |-> !move && !ready && !seg_start)
		else $error("motion or ready during alarm");
	AST_SEG_PULSE: assert property (seg_start |=> !seg_start)
		else $error("segment start longer than one cycle");
endmodule

bind sps_sequencer sps_seq_properties u_sps_seq_properties (
	.aclk                (aclk),
	.aresetn             (aresetn),
	.entry_select_inputs (entry_select_inputs),
	.start               (start),
	.seg_done            (seg_done),
	.ready               (ready),
	.move                (move),
	.alarm               (alarm),
	.seg_start           (seg_start),
	.seg_entry           (seg_entry),
	.seg_blend           (seg_blend),
	.accel_entry         (accel_entry)
);

/* File: sim/stored_positioning_sequencer_test.sv */
// Purpose: directed register and start-sequence tests of the sequencer
// Assumes: dwell tick shortened to 4 cycles
// Notes:   segments are logged as they start
`timescale 1ns/1ns
module stored_positioning_sequencer_test
	import sps_pkg::*;
;
	`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
		$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

	logic        aclk;
	logic        aresetn;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        s_axi_awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        rready;
	logic [5:0]  sel;
	logic        start;
	logic        seg_done;
	logic        ready;
	logic        move;
	logic        alarm;
	logic        seg_start;
	logic [5:0]  seg_entry;
	logic        push_start_speed;
	logic [5:0]  accel_entry;
	logic        irq;
	logic [5:0]  segs[$];
	logic [5:0]  acc;
	logic        psh;
	logic [1:0]  rsp;
	logic [31:0] rd;
	int          dwc;
	int          num_errors;
	int          n_checks;

	sps_sequencer #(.TICK_CYCLES(4)) u_sps_sequencer (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready),
		.entry_select_inputs(sel), .start(start), .seg_done(seg_done), .ready(ready),
		.move(move), .alarm(alarm), .seg_start(seg_start), .seg_entry(seg_entry),
		.seg_blend(), .accel_entry(accel_entry), .push_start_speed(push_start_speed),
		.irq(irq)
	);

	sps_host_model u_sps_host_model (
		.aclk(aclk), .aresetn(aresetn), .ready(ready), .seg_start(seg_start),
		.entry_select_inputs(sel), .start(start), .seg_done(seg_done)
	);

	always #25 aclk = ~aclk;

	// segment log and dwell span counter
	always @(posedge aclk)
	begin
		if (seg_start === 1'b1)
		begin
			segs.push_back(seg_entry);
			acc = accel_entry;
			psh = push_start_speed;
		end
		if (ready === 1'b0 && move === 1'b0 && alarm === 1'b0)
			dwc++;
	end

	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		bit aw, w, b;
		int k;
		aw = 0; w = 0; b = 0; k = 0;
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!b && k < 200)
		begin
			@(posedge aclk);
			k++;
			if (s_axi_awready && !aw) begin aw = 1; awvalid <= 1'b0; end
			if (s_axi_wready && !w) begin w = 1; wvalid <= 1'b0; end
			if (s_axi_bvalid) begin b = 1; rsp = s_axi_bresp; bready <= 1'b0; end
		end
		if (!b) num_errors++;
		@(posedge aclk);
	endtask

	task automatic axr(input logic [11:0] a);
		bit ar, r;
		int k;
		ar = 0; r = 0; k = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!r && k < 200)
		begin
			@(posedge aclk);
			k++;
			if (s_axi_arready && !ar) begin ar = 1; arvalid <= 1'b0; end
			if (s_axi_rvalid) begin r = 1; rd = s_axi_rdata; rsp = s_axi_rresp; rready <= 1'b0; end
		end
		if (!r) num_errors++;
		@(posedge aclk);
	endtask

	task automatic ent(input logic [5:0] n, input sps_func_type f, input logic dir,
		input logic [15:0] dw);
		axw(OFF_TABLE + {4'h0, n, 2'h0}, {dw, 13'h0000, dir, f});
	endtask

	// run entry n and wait for the end or an alarm
	task automatic go(input logic [5:0] n);
		int k;
		segs.delete();
		dwc = 0;
		psh = 1'b0;
		u_sps_host_model.run(n);
		k = 0;
		while (ready !== 1'b1 && alarm !== 1'b1 && k < 400)
		begin
			@(posedge aclk);
			k++;
		end
		repeat (2) @(posedge aclk);
	endtask

	task automatic results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		num_errors++;
		results;
	end

	initial
	begin
		aclk = 1'b0; aresetn = 1'b0; awaddr = 12'h000; awvalid = 1'b0; wdata = 32'h0;
		wvalid = 1'b0; bready = 1'b0; araddr = 12'h000; arvalid = 1'b0; rready = 1'b0;
		num_errors = 0; n_checks = 0; dwc = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK("ready_rst", 1'b1, ready)
		`CHK("irq_rst", 1'b0, irq)
		axr(OFF_IRQ_EN);
		`CHK("irq_en_rst", 32'h0, rd)
		axr(12'h080);
		`CHK("unmapped_resp", RESP_SLVERR, rsp)
		// single motion on an untouched entry, with the done interrupt
		axw(OFF_IRQ_EN, 32'h1);
		go(6'h01);
		`CHK("single_count", 1, segs.size())
		`CHK("single_entry", 6'h01, segs[0])
		`CHK("irq_done", 1'b1, irq)
		axw(OFF_IRQ_CLR, 32'h1);
		`CHK("irq_cleared", 1'b0, irq)
		axw(OFF_IRQ_EN, 32'h0);
		go(6'h01);
		`CHK("irq_masked", 1'b0, irq)
		axr(OFF_IRQ_STAT);
		`CHK("irq_stat_done", 1'b1, rd[IRQ_DONE])
		// linked chain ends at the first single or push entry
		ent(6'h02, FN_LINKED, 1'b0, 16'h0);
		ent(6'h03, FN_LINKED, 1'b0, 16'h0);
		go(6'h02);
		`CHK("link_count", 3, segs.size())
		`CHK("link_last", 6'h04, segs[2])
		`CHK("link_accel", 6'h02, acc)
		`CHK("link_ready", 1'b1, ready)
		ent(6'h05, FN_LINKED, 1'b0, 16'h0);
		ent(6'h06, FN_PUSH, 1'b0, 16'h0);
		go(6'h05);
		`CHK("push_count", 2, segs.size())
		`CHK("push_speed", 1'b1, psh)
		// five entries alarm at start, four do not
		for (int i = 10; i < 14; i++)
			ent(i[5:0], FN_LINKED, 1'b0, 16'h0);
		go(6'h0A);
		`CHK("five_alarm", 1'b1, alarm)
		`CHK("five_segs", 0, segs.size())
		axw(OFF_CTRL, 32'h1);
		@(posedge aclk);
		`CHK("alarm_clear", 1'b1, ready)
		go(6'h0B);
		`CHK("four_count", 4, segs.size())
		`CHK("four_alarm", 1'b0, alarm)
		// reversal inside a linked chain
		ent(6'h14, FN_LINKED, 1'b0, 16'h0);
		ent(6'h15, FN_SINGLE, 1'b1, 16'h0);
		go(6'h14);
		`CHK("reverse_alarm", 1'b1, alarm)
		`CHK("reverse_segs", 1, segs.size())
		axw(OFF_CTRL, 32'h1);
		// last entry never links on to entry zero
		ent(6'h3F, FN_LINKED, 1'b0, 16'h0);
		go(6'h3F);
		`CHK("last_alone", 1, segs.size())
		`CHK("last_alarm", 1'b0, alarm)
		// linked-motion 2 with a 2 ms dwell and a reversal
		ent(6'h1E, FN_LINKED2, 1'b0, 16'h0002);
		ent(6'h1F, FN_SINGLE, 1'b1, 16'h0);
		go(6'h1E);
		`CHK("l2_count", 2, segs.size())
		`CHK("l2_next", 6'h1F, segs[1])
		`CHK("l2_alarm", 1'b0, alarm)
		`CHK("l2_dwell", 1'b1, dwc >= 8 && dwc <= 14)
		axr(OFF_STATUS);
		`CHK("status_word", 32'h00021F01, rd)
		axr(OFF_IRQ_STAT);
		`CHK("irq_stat_dwell", 1'b1, rd[IRQ_DWELL])
		`CHK("irq_stat_alarm", 1'b1, rd[IRQ_ALARM])
		results;
	end
endmodule
